// ==== ooo_params.svh ====
// constants for the issue and retire control: sizes, field positions, reset values
// assumes inclusion by bare name from every design file that needs them
`ifndef OOO_PARAMS_SVH
`define OOO_PARAMS_SVH
`define OOO_PC_W 16
`define OOO_DATA_W 16
`define OOO_LINE_BYTES 64
`define OOO_LINE_OFS_BITS 6
`define OOO_INSN_BITS 32
`define OOO_DELIVER_MAX 3
`define OOO_RETIRE_MAX 3
`define OOO_ISSUE_PORTS 6
`define OOO_ALU_PORTS 4
`define OOO_FP_PORT 4
`define OOO_ROB_DEPTH 16
`define OOO_TRACE_SETS 8
`define OOO_BTB_SETS 16
`define OOO_NUM_REGS 8
`define OOO_RESET_PC 16'h0000
`define OOO_EXC_VECTOR 16'h0100
`define OOO_ALU_LAT 1
`define OOO_ALU_INTERVAL 1
`define OOO_FP_LAT 4
`define OOO_FP_INTERVAL 2
`define OOO_F_CLS_HI 31
`define OOO_F_CLS_LO 30
`define OOO_F_FAULT 29
`define OOO_F_SUB 28
`define OOO_F_DST_LO 24
`define OOO_F_S1_LO 20
`define OOO_F_S2_LO 16
`endif

// ==== ooo_pkg.sv ====
// types shared by the issue and retire control and its execution lanes
// assumes ooo_params.svh is on the include path
`default_nettype none
`include "ooo_params.svh"
package ooo_pkg;
	typedef enum logic [1:0] {CLS_ALU, CLS_FP, CLS_BR, CLS_CPLX} insn_cls_t;
	typedef enum logic [1:0] {TB_IDLE, TB_FETCH, TB_DECODE} tb_state_t;
	typedef struct packed {
		insn_cls_t cls;
		logic sub;
		logic wr;
		logic fault;
		logic [2:0] dst;
		logic [2:0] s1;
		logic [2:0] s2;
		logic [`OOO_PC_W-1:0] pc;
		logic [`OOO_PC_W-1:0] pnpc;
		logic [`OOO_PC_W-1:0] tgt;
	} uop_t;
	typedef struct packed {
		logic v;
		logic taken;
		logic [`OOO_PC_W-1:0] tgt;
	} btb_ent_t;
endpackage
`default_nettype wire

// ==== ooo_exec_lane.sv ====
// one execution lane: fixed latency pipe with a minimum issue interval
// assumes the scheduler only issues while o_ready is high
`timescale 1ns/1ps
`default_nettype none
`include "ooo_params.svh"
module ooo_exec_lane #(
	parameter int LATENCY = `OOO_ALU_LAT,
	parameter int INTERVAL = `OOO_ALU_INTERVAL,
	parameter int W = `OOO_DATA_W,
	parameter int TW = 4
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// issue side
	input wire logic i_flush,
	input wire logic i_issue,
	input wire logic [TW-1:0] i_tag,
	input wire ooo_pkg::insn_cls_t i_cls,
	input wire logic i_sub,
	input wire logic [W-1:0] i_a,
	input wire logic [W-1:0] i_b,
	output logic o_ready,
	// completion side
	output logic o_done,
	output logic [TW-1:0] o_tag,
	output logic [W-1:0] o_val,
	output logic o_taken
);
	typedef struct packed {
		logic v;
		logic [TW-1:0] tag;
		logic [W-1:0] val;
		logic taken;
	} stage_t;
	typedef struct packed {
		stage_t [LATENCY-1:0] pipe;
		logic [3:0] hold;
	} lane_state_t;
	lane_state_t s_r, s_nxt;
	logic [2*W-1:0] prod;
	logic take;
	assign prod = i_a * i_b;
	assign o_ready = (s_r.hold == 4'h0);
	assign take = i_issue && o_ready && !i_flush;
	assign o_done = s_r.pipe[LATENCY-1].v;
	assign o_tag = s_r.pipe[LATENCY-1].tag;
	assign o_val = s_r.pipe[LATENCY-1].val;
	assign o_taken = s_r.pipe[LATENCY-1].taken;
	always_comb begin
		s_nxt = s_r;
		for (int i = LATENCY - 1; i > 0; i--) begin
			s_nxt.pipe[i] = s_r.pipe[i-1];
		end
		s_nxt.pipe[0].v = take;
		s_nxt.pipe[0].tag = i_tag;
		s_nxt.pipe[0].taken = |i_a;
		if (i_cls == ooo_pkg::CLS_FP) begin
			s_nxt.pipe[0].val = prod[W-1:0];
		end else if (i_sub) begin
			s_nxt.pipe[0].val = i_a ^ i_b;
		end else begin
			s_nxt.pipe[0].val = i_a + i_b;
		end
		// slow units block the port for the rest of their interval
		if (take) begin
			s_nxt.hold = 4'(INTERVAL - 1);
		end else if (s_r.hold != 4'h0) begin
			s_nxt.hold = s_r.hold - 4'h1;
		end
		if (i_flush) begin
			for (int i = 0; i < LATENCY; i++) begin
				s_nxt.pipe[i].v = 1'b0;
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	property p_issue_interval;
		@(posedge i_clk) disable iff (!i_resetn)
		(take && INTERVAL > 1) |=> !o_ready;
	endproperty
	a_issue_interval: assert property (p_issue_interval) else $error("lane accepted inside its interval");
	property p_fast_result;
		@(posedge i_clk) disable iff (!i_resetn)
		(take && LATENCY == 1 && INTERVAL == 1) |=> (o_done && o_tag == $past(i_tag) && o_ready);
	endproperty
	a_fast_result: assert property (p_fast_result) else $error("single cycle lane lost a result");
endmodule // ooo_exec_lane
`default_nettype wire

// ==== ooo_pipeline_issue_retire.sv ====
// out-of-order issue and in-order retire control with a trace store front end
// assumes a same-clock fetch port that answers each line request once
// Functional notes
// - front end hands over in program order
// - at most three micro-ops delivered per cycle
// - traces follow predicted path across taken branches
// - hit serves from trace store, miss fetches
// - translator builds predicted-path traces into store
// - fetch missing lines, split complex instructions
// - up to six issue ports per cycle
// - issue out of order once operands ready
// - lanes accept every cycle, float every two
// - commit strictly in program order
// - exceptions raised only at retirement
// - at most three retirements per cycle
// - reorder buffer holds results, orders exceptions
// - retired branches update branch target buffer
// - fetches use 64-byte lines
`timescale 1ns/1ps
`default_nettype none
`include "ooo_params.svh"
module ooo_pipeline_issue_retire #(
	parameter int ROB_DEPTH = `OOO_ROB_DEPTH,
	parameter int TRACE_SETS = `OOO_TRACE_SETS,
	parameter int BTB_SETS = `OOO_BTB_SETS,
	parameter int W = `OOO_DATA_W
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// instruction fetch path
	output logic o_fetch_req,
	output logic [`OOO_PC_W+1:0] o_fetch_addr,
	input wire logic i_fetch_valid,
	input wire logic [`OOO_LINE_BYTES*8-1:0] i_fetch_line,
	// architectural commit
	output logic [`OOO_RETIRE_MAX-1:0] o_commit_valid,
	output logic [`OOO_RETIRE_MAX-1:0][2:0] o_commit_reg,
	output logic [`OOO_RETIRE_MAX-1:0][W-1:0] o_commit_data,
	// exceptions
	output logic o_exc_valid,
	output logic [`OOO_PC_W-1:0] o_exc_pc
);
	localparam int TW = $clog2(ROB_DEPTH);
	localparam int TI = $clog2(TRACE_SETS);
	localparam int BI = $clog2(BTB_SETS);
	localparam int NP = `OOO_ISSUE_PORTS;
	localparam int NR = `OOO_NUM_REGS;
	localparam int PW = `OOO_PC_W;
	typedef struct packed {
		ooo_pkg::uop_t u;
		logic issued;
		logic done;
		logic [1:0] rdy;
		logic [1:0][W-1:0] opv;
		logic [1:0][TW-1:0] opt;
		logic [W-1:0] val;
		logic taken;
	} rob_ent_t;
	typedef struct packed {
		logic v;
		logic [PW-1:0] start;
		logic [1:0] cnt;
		ooo_pkg::uop_t [2:0] u;
		logic [PW-1:0] npc;
	} trace_t;
	typedef struct packed {
		rob_ent_t [ROB_DEPTH-1:0] reorder_buffer;
		logic [TW-1:0] head;
		logic [TW-1:0] tail;
		logic [TW:0] cnt;
		logic [NR-1:0][W-1:0] rf;
		logic [NR-1:0] mp;
		logic [NR-1:0][TW-1:0] mt;
		logic [PW-1:0] pc;
		trace_t [TRACE_SETS-1:0] tc;
		ooo_pkg::btb_ent_t [BTB_SETS-1:0] branch_target_buffer;
		ooo_pkg::tb_state_t tb;
		logic tb_kill;
		logic line_v;
		logic [`OOO_LINE_BYTES*8-1:0] line;
		logic [PW-5:0] line_tag;
		logic [PW-1:0] cur;
		logic [PW-1:0] tb_start;
		logic [1:0] tb_cnt;
		ooo_pkg::uop_t [2:0] tb_u;
		logic [PW+1:0] fetch_addr;
		logic [2:0] cm_v;
		logic [2:0][2:0] cm_reg;
		logic [2:0][W-1:0] cm_val;
		logic exc_v;
		logic [PW-1:0] exc_pc;
	} state_t;
	state_t s_r, s_nxt;
	logic flush, hit, stop, close, dec_br_tk, dec_cplx, btb_upd, tc_wr, ptk;
	logic [PW-1:0] redirect, anpc, dec_tgt, npc;
	logic [1:0] rcnt, dcnt, need;
	logic [2:0] sum;
	logic [TW:0] free;
	logic [TW-1:0] idx;
	logic [2:0] r;
	logic [BI-1:0] btb_idx;
	logic [PW-1:0] btb_tgt;
	logic [TI-1:0] tidx;
	logic [`OOO_INSN_BITS-1:0] insn;
	ooo_pkg::insn_cls_t cls;
	ooo_pkg::uop_t u0, u1;
	ooo_pkg::btb_ent_t b;
	trace_t t;
	rob_ent_t e;
	logic [NR-1:0] grp_p;
	logic [NR-1:0][TW-1:0] grp_t;
	logic [NP-1:0] iss_v, lane_rdy, lane_done, lane_tk;
	logic [NP-1:0][TW-1:0] iss_tag, lane_tag;
	logic [NP-1:0][W-1:0] iss_a, iss_b, lane_val;
	ooo_pkg::insn_cls_t [NP-1:0] iss_cls;
	logic [NP-1:0] iss_sub;

	function automatic ooo_pkg::insn_cls_t port_cls(input int p);
		if (p < `OOO_ALU_PORTS) begin
			return ooo_pkg::CLS_ALU;
		end else if (p == `OOO_FP_PORT) begin
			return ooo_pkg::CLS_FP;
		end
		return ooo_pkg::CLS_BR;
	endfunction

	assign o_fetch_req = (s_r.tb == ooo_pkg::TB_FETCH);
	assign o_fetch_addr = s_r.fetch_addr;
	assign o_commit_valid = s_r.cm_v;
	assign o_commit_reg = s_r.cm_reg;
	assign o_commit_data = s_r.cm_val;
	assign o_exc_valid = s_r.exc_v;
	assign o_exc_pc = s_r.exc_pc;
	assign t = s_r.tc[s_r.pc[TI-1:0]];
	assign hit = t.v && (t.start == s_r.pc);
	assign free = (TW+1)'(ROB_DEPTH) - s_r.cnt;
	assign insn = s_r.line[{s_r.cur[3:0], 5'h00} +: `OOO_INSN_BITS];

	always_comb begin
		s_nxt = s_r;
		s_nxt.cm_v = '0;
		s_nxt.exc_v = 1'b0;
		flush = 1'b0; stop = 1'b0; close = 1'b0; ptk = 1'b0;
		redirect = s_r.pc; anpc = '0; npc = '0; dec_tgt = '0;
		rcnt = 2'h0; dcnt = 2'h0; need = 2'h1; sum = 3'h0;
		idx = '0; r = '0; e = '0; u0 = '0; u1 = '0; b = '0; cls = ooo_pkg::CLS_ALU;
		grp_p = '0; grp_t = '0; iss_v = '0; iss_tag = '0; iss_a = '0; iss_b = '0;
		iss_sub = '0; btb_upd = 1'b0; btb_idx = '0; btb_tgt = '0;
		// enum lanes take a named value, not a bare zero
		for (int p = 0; p < NP; p++) begin
			iss_cls[p] = ooo_pkg::CLS_ALU;
		end
		tc_wr = 1'b0; tidx = '0; dec_br_tk = 1'b0; dec_cplx = 1'b0;
		// results held in the buffer until their turn to commit
		for (int p = 0; p < NP; p++) begin
			if (lane_done[p]) begin
				s_nxt.reorder_buffer[lane_tag[p]].done = 1'b1;
				s_nxt.reorder_buffer[lane_tag[p]].val = lane_val[p];
				s_nxt.reorder_buffer[lane_tag[p]].taken = lane_tk[p];
			end
		end
		// operand capture from finished producers; safe since producers retire no earlier
		for (int k = 0; k < ROB_DEPTH; k++) begin
			for (int q = 0; q < 2; q++) begin
				if (!s_r.reorder_buffer[k].rdy[q] && s_r.reorder_buffer[s_r.reorder_buffer[k].opt[q]].done) begin
					s_nxt.reorder_buffer[k].rdy[q] = 1'b1;
					s_nxt.reorder_buffer[k].opv[q] = s_r.reorder_buffer[s_r.reorder_buffer[k].opt[q]].val;
				end
			end
		end
		// in-order retire, first unfinished entry stops the group
		for (int k = 0; k < `OOO_RETIRE_MAX; k++) begin
			idx = TW'(s_r.head + TW'(k));
			e = s_r.reorder_buffer[idx];
			if (!stop && ((TW+1)'(k) < s_r.cnt) && e.done) begin
				rcnt = rcnt + 2'h1;
				if (e.u.fault) begin
					s_nxt.exc_v = 1'b1;
					s_nxt.exc_pc = e.u.pc;
					flush = 1'b1;
					redirect = `OOO_EXC_VECTOR;
					stop = 1'b1;
				end else begin
					if (e.u.wr) begin
						s_nxt.rf[e.u.dst] = e.val;
						s_nxt.cm_v[k] = 1'b1;
						s_nxt.cm_reg[k] = e.u.dst;
						s_nxt.cm_val[k] = e.val;
						if (s_r.mp[e.u.dst] && s_r.mt[e.u.dst] == idx) begin
							s_nxt.mp[e.u.dst] = 1'b0;
						end
					end
					if (e.u.cls == ooo_pkg::CLS_BR) begin
						anpc = e.taken ? e.u.tgt : e.u.pc + 16'h0001;
						btb_upd = 1'b1;
						btb_idx = e.u.pc[BI-1:0];
						btb_tgt = e.u.tgt;
						s_nxt.branch_target_buffer[btb_idx] = '{v: 1'b1, taken: e.taken, tgt: e.u.tgt};
						if (anpc != e.u.pnpc) begin
							flush = 1'b1;
							redirect = anpc;
							stop = 1'b1;
						end
					end
				end
			end else begin
				stop = 1'b1;
			end
		end
		s_nxt.head = TW'(s_r.head + TW'(rcnt));
		s_nxt.cnt = s_r.cnt - (TW+1)'(rcnt);
		// oldest ready entry wins each free port
		for (int p = 0; p < NP; p++) begin
			for (int k = 0; k < ROB_DEPTH; k++) begin
				idx = TW'(s_r.head + TW'(k));
				if (!iss_v[p] && !flush && lane_rdy[p] && ((TW+1)'(k) < s_r.cnt) &&
						!s_nxt.reorder_buffer[idx].issued && (&s_r.reorder_buffer[idx].rdy) &&
						s_r.reorder_buffer[idx].u.cls == port_cls(p)) begin
					iss_v[p] = 1'b1;
					iss_tag[p] = idx;
					iss_a[p] = s_r.reorder_buffer[idx].opv[0];
					iss_b[p] = s_r.reorder_buffer[idx].opv[1];
					iss_cls[p] = s_r.reorder_buffer[idx].u.cls;
					iss_sub[p] = s_r.reorder_buffer[idx].u.sub;
					s_nxt.reorder_buffer[idx].issued = 1'b1;
				end
			end
		end
		// delivery waits whole until the buffer has room for the trace
		if (hit && !flush && free >= (TW+1)'(t.cnt)) begin
			dcnt = t.cnt;
			for (int j = 0; j < `OOO_DELIVER_MAX; j++) begin
				if (2'(j) < t.cnt) begin
					idx = TW'(s_r.tail + TW'(j));
					e = '0;
					e.u = t.u[j];
					e.issued = t.u[j].fault;
					e.done = t.u[j].fault;
					for (int q = 0; q < 2; q++) begin
						r = (q == 1) ? t.u[j].s2 : t.u[j].s1;
						if (q == 1 && t.u[j].cls == ooo_pkg::CLS_BR) begin
							e.rdy[q] = 1'b1;
						end else if (grp_p[r]) begin
							e.opt[q] = grp_t[r];
						end else if (s_r.mp[r] && !s_r.reorder_buffer[s_r.mt[r]].done) begin
							e.opt[q] = s_r.mt[r];
						end else begin
							e.rdy[q] = 1'b1;
							e.opv[q] = s_r.mp[r] ? s_r.reorder_buffer[s_r.mt[r]].val : s_r.rf[r];
						end
					end
					if (t.u[j].wr) begin
						grp_p[t.u[j].dst] = 1'b1;
						grp_t[t.u[j].dst] = idx;
						s_nxt.mp[t.u[j].dst] = 1'b1;
						s_nxt.mt[t.u[j].dst] = idx;
					end
					s_nxt.reorder_buffer[idx] = e;
				end
			end
			s_nxt.tail = TW'(s_r.tail + TW'(dcnt));
			s_nxt.cnt = s_nxt.cnt + (TW+1)'(dcnt);
			s_nxt.pc = t.npc;
		end
		case (s_r.tb)
			ooo_pkg::TB_IDLE: begin
				if (!hit && !flush) begin
					s_nxt.tb_start = s_r.pc;
					s_nxt.cur = s_r.pc;
					s_nxt.tb_cnt = 2'h0;
					s_nxt.fetch_addr = {s_r.pc[PW-1:4], 6'h00};
					s_nxt.tb = (s_r.line_v && s_r.line_tag == s_r.pc[PW-1:4]) ?
						ooo_pkg::TB_DECODE : ooo_pkg::TB_FETCH;
				end
			end
			ooo_pkg::TB_FETCH: begin
				if (i_fetch_valid) begin
					s_nxt.line = i_fetch_line;
					s_nxt.line_v = 1'b1;
					s_nxt.line_tag = s_r.fetch_addr[PW+1:`OOO_LINE_OFS_BITS];
					s_nxt.tb = s_r.tb_kill ? ooo_pkg::TB_IDLE : ooo_pkg::TB_DECODE;
					s_nxt.tb_kill = 1'b0;
				end
			end
			ooo_pkg::TB_DECODE: begin
				if (s_r.cur[PW-1:4] != s_r.line_tag) begin
					s_nxt.tb = ooo_pkg::TB_FETCH;
					s_nxt.fetch_addr = {s_r.cur[PW-1:4], 6'h00};
				end else begin
					cls = ooo_pkg::insn_cls_t'(insn[`OOO_F_CLS_HI:`OOO_F_CLS_LO]);
					dec_cplx = (cls == ooo_pkg::CLS_CPLX);
					need = dec_cplx ? 2'h2 : 2'h1;
					sum = {1'b0, s_r.tb_cnt} + {1'b0, need};
					if (sum > 3'h3) begin
						close = 1'b1;
						dec_cplx = 1'b0;
					end else begin
						u0.cls = dec_cplx ? ooo_pkg::CLS_ALU : cls;
						u0.sub = dec_cplx | insn[`OOO_F_SUB];
						u0.wr = (cls != ooo_pkg::CLS_BR);
						u0.fault = insn[`OOO_F_FAULT];
						u0.dst = insn[`OOO_F_DST_LO +: 3];
						u0.s1 = insn[`OOO_F_S1_LO +: 3];
						u0.s2 = insn[`OOO_F_S2_LO +: 3];
						u0.pc = s_r.cur;
						u0.tgt = insn[PW-1:0];
						dec_tgt = u0.tgt;
						b = s_r.branch_target_buffer[s_r.cur[BI-1:0]];
						ptk = b.v ? b.taken : (u0.tgt < s_r.cur);
						dec_br_tk = (cls == ooo_pkg::CLS_BR) && ptk;
						// skipped-over code never enters the trace
						npc = dec_br_tk ? u0.tgt : s_r.cur + 16'h0001;
						u0.pnpc = npc;
						s_nxt.tb_u[s_r.tb_cnt] = u0;
						u1 = u0;
						u1.sub = 1'b0;
						u1.fault = 1'b0;
						u1.s1 = u0.dst;
						if (dec_cplx) begin
							s_nxt.tb_u[s_r.tb_cnt + 2'h1] = u1;
						end
						s_nxt.tb_cnt = sum[1:0];
						s_nxt.cur = npc;
						close = (sum == 3'h3) || u0.fault;
					end
					if (close) begin
						tc_wr = 1'b1;
						tidx = s_r.tb_start[TI-1:0];
						s_nxt.tc[tidx] = '{v: 1'b1, start: s_r.tb_start, cnt: s_nxt.tb_cnt,
							u: s_nxt.tb_u, npc: s_nxt.cur};
						s_nxt.tb = ooo_pkg::TB_IDLE;
					end
				end
			end
			default: begin
				s_nxt.tb = ooo_pkg::TB_IDLE;
			end
		endcase
		// squash all speculative work; an open fetch is let finish then dropped
		if (flush) begin
			s_nxt.cnt = '0;
			s_nxt.tail = s_nxt.head;
			s_nxt.mp = '0;
			s_nxt.pc = redirect;
			for (int k = 0; k < TRACE_SETS; k++) begin
				s_nxt.tc[k].v = 1'b0;
			end
			s_nxt.tb_kill = (s_r.tb == ooo_pkg::TB_FETCH) && !i_fetch_valid;
			s_nxt.tb = s_nxt.tb_kill ? ooo_pkg::TB_FETCH : ooo_pkg::TB_IDLE;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_r <= '0;
			s_r.pc <= `OOO_RESET_PC;
		end else begin
			s_r <= s_nxt;
		end
	end

	generate
		for (genvar p = 0; p < NP; p++) begin : g_lane
			ooo_exec_lane #(
				.LATENCY((p == `OOO_FP_PORT) ? `OOO_FP_LAT : `OOO_ALU_LAT),
				.INTERVAL((p == `OOO_FP_PORT) ? `OOO_FP_INTERVAL : `OOO_ALU_INTERVAL),
				.W(W),
				.TW(TW)
			) u_lane (
				.i_clk(i_clk),
				.i_resetn(i_resetn),
				.i_flush(flush),
				.i_issue(iss_v[p]),
				.i_tag(iss_tag[p]),
				.i_cls(iss_cls[p]),
				.i_sub(iss_sub[p]),
				.i_a(iss_a[p]),
				.i_b(iss_b[p]),
				.o_ready(lane_rdy[p]),
				.o_done(lane_done[p]),
				.o_tag(lane_tag[p]),
				.o_val(lane_val[p]),
				.o_taken(lane_tk[p])
			);
		end
	endgenerate

	property p_deliver_order;
		@(posedge i_clk) disable iff (!i_resetn)
		(dcnt != 2'h0) |=> (s_r.tail == TW'($past(s_r.tail) + $past(dcnt)));
	endproperty
	a_deliver_order: assert property (p_deliver_order) else $error("delivery skipped a slot");
	property p_deliver_width;
		@(posedge i_clk) disable iff (!i_resetn)
		(dcnt != 2'h0) |-> (hit && dcnt == t.cnt && free >= (TW+1)'(dcnt));
	endproperty
	a_deliver_width: assert property (p_deliver_width) else $error("bad delivery group");
	property p_stall_hold;
		@(posedge i_clk) disable iff (!i_resetn)
		(hit && !flush && free < (TW+1)'(t.cnt)) |=> (s_r.pc == $past(s_r.pc));
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("front end moved while full");
	property p_taken_path;
		@(posedge i_clk) disable iff (!i_resetn)
		(dec_br_tk && !flush) |=> (s_r.cur == $past(dec_tgt));
	endproperty
	a_taken_path: assert property (p_taken_path) else $error("trace left predicted path");
	property p_miss_fetch;
		@(posedge i_clk) disable iff (!i_resetn)
		(s_r.tb == ooo_pkg::TB_IDLE && !hit && !flush) |=> (s_r.tb != ooo_pkg::TB_IDLE);
	endproperty
	a_miss_fetch: assert property (p_miss_fetch) else $error("miss not serviced");
	property p_trace_store;
		@(posedge i_clk) disable iff (!i_resetn)
		(tc_wr && !flush) |=> (s_r.tc[$past(tidx)].v && s_r.tc[$past(tidx)].start == $past(s_r.tb_start));
	endproperty
	a_trace_store: assert property (p_trace_store) else $error("trace not stored");
	property p_cplx_split;
		@(posedge i_clk) disable iff (!i_resetn)
		dec_cplx |=> (s_r.tb_cnt == $past(s_r.tb_cnt) + 2'h2);
	endproperty
	a_cplx_split: assert property (p_cplx_split) else $error("complex op not split");
	property p_line_addr;
		@(posedge i_clk) disable iff (!i_resetn)
		o_fetch_req |-> (o_fetch_addr[5:0] == 6'h00);
	endproperty
	a_line_addr: assert property (p_line_addr) else $error("fetch not line aligned");
	property p_issue_ready;
		@(posedge i_clk) disable iff (!i_resetn)
		iss_v[0] |-> ((&s_r.reorder_buffer[iss_tag[0]].rdy) && !s_r.reorder_buffer[iss_tag[0]].issued && lane_rdy[0]);
	endproperty
	a_issue_ready: assert property (p_issue_ready) else $error("issued before ready");
	property p_issue_distinct;
		@(posedge i_clk) disable iff (!i_resetn)
		(iss_v[0] && iss_v[1]) |-> (iss_tag[0] != iss_tag[1]);
	endproperty
	a_issue_distinct: assert property (p_issue_distinct) else $error("one entry on two ports");
	property p_retire_head;
		@(posedge i_clk) disable iff (!i_resetn)
		(rcnt != 2'h0) |-> (s_r.reorder_buffer[s_r.head].done && s_r.cnt != '0);
	endproperty
	a_retire_head: assert property (p_retire_head) else $error("retired past unfinished head");
	property p_retire_advance;
		@(posedge i_clk) disable iff (!i_resetn)
		(rcnt != 2'h0) |=> (s_r.head == TW'($past(s_r.head) + $past(rcnt)));
	endproperty
	a_retire_advance: assert property (p_retire_advance) else $error("retire count wrong");
	property p_exc_flush;
		@(posedge i_clk) disable iff (!i_resetn)
		// older slots of the same group may still commit beside the fault
		o_exc_valid |-> (s_r.cnt == '0 && s_r.pc == `OOO_EXC_VECTOR &&
			!o_commit_valid[`OOO_RETIRE_MAX-1]);
	endproperty
	a_exc_flush: assert property (p_exc_flush) else $error("exception without squash");
	property p_btb_update;
		@(posedge i_clk) disable iff (!i_resetn)
		btb_upd |=> (s_r.branch_target_buffer[$past(btb_idx)].v && s_r.branch_target_buffer[$past(btb_idx)].tgt == $past(btb_tgt));
	endproperty
	a_btb_update: assert property (p_btb_update) else $error("branch buffer not updated");
	c_deliver3: cover property (@(posedge i_clk) disable iff (!i_resetn) dcnt == 2'h3);
	c_retire3: cover property (@(posedge i_clk) disable iff (!i_resetn) rcnt == 2'h3);
	c_exception: cover property (@(posedge i_clk) disable iff (!i_resetn) o_exc_valid);
	c_mispredict: cover property (@(posedge i_clk) disable iff (!i_resetn) flush && !s_nxt.exc_v);
endmodule // ooo_pipeline_issue_retire
`default_nettype wire

// ==== ooo_fetch_mem.sv ====
// fetch port partner: program memory answering line requests
// assumes the bench loads words before reset is released
`timescale 1ns/1ps
`default_nettype none
module ooo_fetch_mem (
	// clock
	input wire logic i_clk,
	// request side
	input wire logic i_req,
	input wire logic [17:0] i_addr,
	// answer side
	output logic o_valid,
	output logic [511:0] o_line
);
	logic [31:0] words [0:511];
	int cnt;
	initial begin
		o_valid = 1'b0;
		o_line = '0;
		cnt = -1;
	end
	// answers 0..3 cycles late; data is junk outside the answer cycle
	always @(posedge i_clk) begin
		#1;
		if (o_valid) begin
			o_valid = 1'b0;
			cnt = -1;
		end else if (i_req) begin
			if (cnt < 0) cnt = $urandom_range(3, 0);
			if (cnt == 0) begin
				o_valid = 1'b1;
				for (int k = 0; k < 16; k++) o_line[32*k+:32] = words[{i_addr[10:6], k[3:0]}];
			end else cnt--;
		end
		if (!o_valid) o_line = {16{$urandom}};
	end
endmodule // ooo_fetch_mem
`default_nettype wire

// ==== tb_ooo_pipeline_issue_retire.sv ====
// self-checking bench: random program, fault ends each region
// assumes all registers start at zero, so committed data stays zero
`timescale 1ns/1ps
`default_nettype none
module tb_ooo_pipeline_issue_retire;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic o_fetch_req;
	logic [17:0] o_fetch_addr;
	logic i_fetch_valid;
	logic [511:0] i_fetch_line;
	logic [2:0] o_commit_valid;
	logic [2:0][2:0] o_commit_reg;
	logic [2:0][15:0] o_commit_data;
	logic o_exc_valid;
	logic [15:0] o_exc_pc;
	logic [16:0] eq [$];
	int n_errors = 0;
	int checked = 0;
	always #2.5 i_clk = ~i_clk;
	ooo_pipeline_issue_retire dut (.i_clk(i_clk), .i_resetn(i_resetn),
		.o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr),
		.i_fetch_valid(i_fetch_valid), .i_fetch_line(i_fetch_line),
		.o_commit_valid(o_commit_valid), .o_commit_reg(o_commit_reg),
		.o_commit_data(o_commit_data), .o_exc_valid(o_exc_valid), .o_exc_pc(o_exc_pc));
	ooo_fetch_mem mem (.i_clk(i_clk), .i_req(o_fetch_req), .i_addr(o_fetch_addr),
		.o_valid(i_fetch_valid), .o_line(i_fetch_line));
	task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude();
		if (n_errors == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// architectural walk: branches never taken since registers stay zero
	function automatic logic [15:0] walk(input logic [15:0] pc);
		logic [31:0] w;
		w = mem.words[pc[8:0]];
		while (w[29] !== 1'b1) begin
			if (w[31:30] != 2'h2) eq.push_back({1'b0, 13'h0000, w[26:24]});
			if (w[31:30] == 2'h3) eq.push_back({1'b0, 13'h0000, w[26:24]});
			pc++;
			w = mem.words[pc[8:0]];
		end
		eq.push_back({1'b1, pc});
		return pc;
	endfunction
	// random region; branch targets stay inside it, both directions
	task automatic fill(input int base, input int len);
		logic [31:0] w;
		for (int i = 0; i < len; i++) begin
			w = $urandom;
			w[29] = 1'b0;
			w[15:0] = 16'(base + $urandom_range(len - 1, 0));
			mem.words[base + i] = w;
		end
		mem.words[base + len] = 32'h2000_0000;
	endtask
	// monitor samples settled outputs on the falling edge
	always @(negedge i_clk) begin
		if (i_resetn && eq.size() > 0) begin
			if (o_fetch_req === 1'b1) check("fetch_ofs", 17'h0_0000, {11'h000, o_fetch_addr[5:0]});
			for (int k = 0; k < 3; k++) begin
				if (o_commit_valid[k] === 1'b1 && eq.size() > 0) begin
					// branches commit nothing, so a gap below is legal; a fault takes one of the three retire slots
					check("retire_width", 17'h0_0000, {16'h0000, k == 2 && o_exc_valid === 1'b1});
					check("commit_reg", eq.pop_front(), {1'b0, 13'h0000, o_commit_reg[k]});
					check("commit_data", 17'h0_0000, {1'b0, o_commit_data[k]});
				end
			end
			if (o_exc_valid === 1'b1 && eq.size() > 0) check("exc_pc", eq.pop_front(), {1'b1, o_exc_pc});
		end
	end
	initial begin
		logic [15:0] f;
		int n;
		void'($urandom(32'h82d3_0295));
		// clear here, not in the memory, so no time-zero race with the fill
		for (int i = 0; i < 512; i++) begin
			mem.words[i] = 32'h0000_0000;
		end
		fill(0, 40);
		fill(256, 30);
		f = walk(16'h0000);
		f = walk(16'h0100);
		repeat (12) @(posedge i_clk);
		#1 i_resetn = 1'b1;
		n = 0;
		while (eq.size() > 0 && n < 30000) begin
			@(posedge i_clk);
			n++;
		end
		if (eq.size() > 0) begin
			n_errors++;
			$display("BAD commit_stream expected %0d more seen timeout", eq.size());
		end
		// reset in mid-run, then region one must replay from the start
		#1 i_resetn = 1'b0;
		f = walk(16'h0000);
		repeat (3) @(posedge i_clk);
		#1 i_resetn = 1'b1;
		n = 0;
		while (eq.size() > 0 && n < 30000) begin
			@(posedge i_clk);
			n++;
		end
		if (eq.size() > 0) begin
			n_errors++;
			$display("BAD replay_stream expected %0d more seen timeout", eq.size());
		end
		conclude();
	end
endmodule // tb_ooo_pipeline_issue_retire
`default_nettype wire
